// ---- design/cps_core.sv ----
// CPU core state, reset sequencer, interrupt latches, priority decision and low-power wake.
// Assumes commands, events and memory data come from logic on i_clk; pins are synchronised here.
//
// Summary of operation
// - 8-bit accumulator holds operands and results
// - Two 8-bit pointer registers, primary and secondary
// - Interrupt entry leaves secondary pointer untouched
// - 16-bit program counter in two bytes
// - Core registers reached only by dedicated commands
// - Bit 1 flags a zero result
// - Bit 0 flags carry, settable by commands
// - Bit test, shift, rotate update carry
// - Priority bits 5,3 encode four levels
// - Entry loads priority from software priority field
// - Priority bits written by listed commands
// - Three reset sources all act on pin
// - Reset pin held low through delay
// - Active phase, delay, then vector fetch
// - Delay 256 or 4096 cycles by option
// - Reset vector read from FFFE and FFFF
// - Oscillator stays running through reset
// - IT0..IT4 requests latch only when enabled; top-level always latches
// - Status read then associated access clears
// - Clearing discards a still pending request
// - Any request wakes wait; capable ones halt
// - First service after halt is capable source
// - Higher non-capable request follows right after
// - Hardware order main, IT4..IT0, top-level
// - Halt entry forces priority bits to 10
`timescale 1ns/100ps
module cps_core (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire cps_pkg::cps_cmd_t i_cmd,
  input wire cps_pkg::cps_bus_t i_bus,
  input wire logic [4:0] i_irq_evt,
  input wire logic i_tli_pin,
  input wire logic i_rst_pin,
  input wire logic i_lvd_rst,
  input wire logic i_wdg_rst,
  input wire logic i_opt_long_dly,
  input wire logic [7:0] i_mem_data,
  output logic [7:0] o_rd_data,
  output logic [7:0] o_acc,
  output logic [7:0] o_x,
  output logic [7:0] o_y,
  output logic [15:0] o_pc,
  output logic [7:0] o_cc,
  output logic o_irq_take,
  output logic [2:0] o_irq_vec,
  output logic o_mem_rd,
  output logic [15:0] o_mem_addr,
  output logic o_rst_pin_o,
  output logic o_rst_pin_oe_n,
  output logic o_osc_en,
  output logic o_run
);
  import cps_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers; only the second stage is read by logic
  logic [3:0] sy1_q;
  logic [3:0] sy2_q;
  logic tli_prev_q;
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      sy1_q <= 4'hF;
      sy2_q <= 4'hF;
      tli_prev_q <= 1'b1;
    end else begin
      sy1_q <= {i_opt_long_dly, ~i_lvd_rst, i_rst_pin, i_tli_pin};
      sy2_q <= sy1_q;
      tli_prev_q <= sy2_q[0];
    end
  end
  wire logic tli_fall = tli_prev_q && !sy2_q[0];
  wire logic pin_low = !sy2_q[1];
  wire logic lvd_act = !sy2_q[2];

  ////////////////////////////////////////////////////////////////////////////////
  // Decoding shared by the decision and the checks
  // Priority encoding to a comparable level
  function automatic logic [1:0] lvl(input logic [1:0] e);
    case (e)
      PRI_L0: lvl = 2'h0;
      PRI_L1: lvl = 2'h1;
      PRI_L2: lvl = 2'h2;
      default: lvl = 2'h3;
    endcase
  endfunction

  function automatic logic [1:0] fld(input logic [15:0] s, input int i);
    if (i == TLI_IDX) begin
      fld = PRI_L3;
    end else begin
      fld = s[2*i +: 2];
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // State
  cps_state_t st_q, st_d;
  logic [12:0] cnt_q, cnt_d;
  logic [1:0] src_q, src_d;
  logic long_q, long_d;
  logic [7:0] acc_q, acc_d, x_q, x_d, y_q, y_d, cc_q, cc_d;
  logic [15:0] pc_q, pc_d;
  logic [7:0] spr0_q, spr0_d, spr1_q, spr1_d, en_q, en_d, rd_q, rd_d;
  logic [5:0] pend_q, pend_d, arm_q, arm_d, set_v, clr_v;
  logic [2:0] wake_q, wake_d, vec_q, vec_d;
  logic take_q, take_d, mrd_q, mrd_d, pdrv_q, pdrv_d, osc_q, osc_d;
  logic run_q, run_d;
  // Own drive history; the pin read-back lags our release by the synchroniser depth
  logic [1:0] pdrv_h_q;
  logic [15:0] maddr_q, maddr_d;

  // Decision outputs
  logic [5:0] cand;
  logic found, found_h;
  logic [2:0] best, best_h;
  logic [1:0] bl, bl_h, cur;
  logic [8:0] alu;
  int idx;

  always_comb begin
    cur = lvl({cc_q[CC_I1], cc_q[CC_I0]});
    found = 1'b0;
    found_h = 1'b0;
    best = 3'h0;
    best_h = 3'h0;
    bl = 2'h0;
    bl_h = 2'h0;
    idx = 0;
    // Walk from lowest to highest hardware priority so ties go to the higher one
    for (int k = 0; k < NSRC; k++) begin
      idx = (k < 5) ? 4 - k : TLI_IDX;
      cand[idx] = pend_q[idx] && (lvl(fld({spr1_q, spr0_q}, idx)) > cur);
      if (cand[idx] && (!found || lvl(fld({spr1_q, spr0_q}, idx)) >= bl)) begin
        found = 1'b1;
        best = idx[2:0];
        bl = lvl(fld({spr1_q, spr0_q}, idx));
      end
      if (cand[idx] && HALT_CAP[idx] && (!found_h || lvl(fld({spr1_q, spr0_q}, idx)) >= bl_h)) begin
        found_h = 1'b1;
        best_h = idx[2:0];
        bl_h = lvl(fld({spr1_q, spr0_q}, idx));
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    src_d = src_q;
    long_d = long_q;
    acc_d = acc_q;
    x_d = x_q;
    y_d = y_q;
    cc_d = cc_q;
    pc_d = pc_q;
    spr0_d = spr0_q;
    spr1_d = spr1_q;
    en_d = en_q;
    rd_d = REG8_RST;
    arm_d = arm_q;
    wake_d = wake_q;
    vec_d = vec_q;
    take_d = 1'b0;
    mrd_d = 1'b0;
    maddr_d = maddr_q;
    pdrv_d = pdrv_q;
    osc_d = 1'b1;
    alu = 9'h000;
    clr_v = 6'h00;

    // Registers on the plain port; core registers have no address here
    if (i_bus.wr) begin
      if (i_bus.addr == A_SPR0) begin
        spr0_d = i_bus.wdata;
      end else if (i_bus.addr == A_SPR1) begin
        spr1_d = i_bus.wdata;
      end else if (i_bus.addr == A_EN) begin
        en_d = i_bus.wdata;
      end
    end
    if (i_bus.rd) begin
      if (i_bus.addr == A_SPR0) begin
        rd_d = spr0_q;
      end else if (i_bus.addr == A_SPR1) begin
        rd_d = spr1_q;
      end else if (i_bus.addr == A_EN) begin
        rd_d = en_q;
      end else if (i_bus.addr == A_STAT) begin
        rd_d = {2'h0, pend_q};
      end else if (i_bus.addr == A_SYS) begin
        rd_d = {long_q, src_q, 1'b0, st_q};
      end
    end
    // Status read arms; the very next access, if to the ack register, clears what was seen; any other access disarms
    if (i_bus.rd || i_bus.wr) begin
      if (i_bus.addr == A_ACK) begin
        clr_v = arm_q;
      end
      arm_d = (i_bus.rd && i_bus.addr == A_STAT) ? pend_q : 6'h00;
    end

    case (st_q)
      ST_RST_ACT: begin
        pdrv_d = 1'b1;
        long_d = sy2_q[3];
        cnt_d = cnt_q + 13'h0001;
        // A held low-voltage condition stretches the active phase
        if (lvd_act) begin
          cnt_d = 13'h0000;
        end else if (cnt_q >= ((src_q == SRC_EXT) ? ACT_EXT_CYC : ACT_INT_CYC) - 13'h0001) begin
          st_d = ST_RST_DLY;
          cnt_d = 13'h0000;
        end
      end
      ST_RST_DLY: begin
        pdrv_d = 1'b1;
        cnt_d = cnt_q + 13'h0001;
        if (cnt_q == (long_q ? DLY_LONG_CYC : DLY_SHORT_CYC) - 13'h0001) begin
          st_d = ST_VEC_HI;
          pdrv_d = 1'b0;
          mrd_d = 1'b1;
          maddr_d = VEC_HI_ADDR;
        end
      end
      ST_VEC_HI: begin
        st_d = ST_VEC_LO;
        mrd_d = 1'b1;
        maddr_d = VEC_LO_ADDR;
      end
      ST_VEC_LO: begin
        st_d = ST_VEC_END;
        pc_d[15:8] = i_mem_data;
      end
      ST_VEC_END: begin
        st_d = ST_RUN;
        pc_d[7:0] = i_mem_data;
      end
      ST_RUN: begin
        if (i_cmd.vld) begin
          pc_d = pc_q + 16'h0001;
          case (i_cmd.op)
            OP_LD_A: acc_d = i_cmd.data;
            OP_LD_X: x_d = i_cmd.data;
            OP_LD_Y: y_d = i_cmd.data;
            OP_ADD: alu = {1'b0, acc_q} + {1'b0, i_cmd.data};
            OP_SUB: alu = {1'b0, acc_q} - {1'b0, i_cmd.data};
            OP_AND: alu = {cc_q[CC_C], acc_q & i_cmd.data};
            OP_OR: alu = {cc_q[CC_C], acc_q | i_cmd.data};
            OP_SHL: alu = {acc_q, 1'b0};
            OP_ROL: alu = {acc_q, cc_q[CC_C]};
            OP_BTJ: cc_d[CC_C] = acc_q[i_cmd.data[2:0]];
            OP_SCF: cc_d[CC_C] = 1'b1;
            OP_RCF: cc_d[CC_C] = 1'b0;
            OP_BR_EQ, OP_BR_NE, OP_BR_C, OP_BR_NC: begin
              if ((i_cmd.op == OP_BR_EQ && cc_q[CC_Z]) || (i_cmd.op == OP_BR_NE && !cc_q[CC_Z]) ||
                  (i_cmd.op == OP_BR_C && cc_q[CC_C]) || (i_cmd.op == OP_BR_NC && !cc_q[CC_C])) begin
                pc_d = pc_q + 16'h0001 + {{8{i_cmd.data[7]}}, i_cmd.data};
              end
            end
            OP_RIM: {cc_d[CC_I1], cc_d[CC_I0]} = PRI_L0;
            OP_SIM: {cc_d[CC_I1], cc_d[CC_I0]} = PRI_L3;
            OP_RETURN_FROM_INTERRUPT_INSTRUCTION, OP_POP_CC: cc_d = i_cmd.data;
            OP_LD_PCL: pc_d[7:0] = i_cmd.data;
            OP_LD_PCH: pc_d[15:8] = i_cmd.data;
            OP_HALT: begin
              {cc_d[CC_I1], cc_d[CC_I0]} = PRI_L0;
              st_d = ST_HALT;
              osc_d = 1'b0;
            end
            OP_WFI: begin
              {cc_d[CC_I1], cc_d[CC_I0]} = PRI_L0;
              st_d = ST_WAIT;
            end
            default: pc_d = pc_q + 16'h0001;
          endcase
          if (i_cmd.op inside {OP_ADD, OP_SUB, OP_AND, OP_OR, OP_SHL, OP_ROL}) begin
            acc_d = alu[7:0];
            cc_d[CC_Z] = (alu[7:0] == 8'h00);
            cc_d[CC_C] = alu[8];
          end
        end else if (found) begin
          // Entry only between commands; the secondary pointer is never touched
          take_d = 1'b1;
          vec_d = best;
          {cc_d[CC_I1], cc_d[CC_I0]} = fld({spr1_q, spr0_q}, int'(best));
        end
      end
      ST_WAIT: begin
        if (found) begin
          st_d = ST_RUN;
        end
      end
      ST_HALT: begin
        osc_d = 1'b0;
        if (found_h) begin
          // Oscillator restarts and waits out the stabilisation delay
          st_d = ST_HALT_DLY;
          wake_d = best_h;
          cnt_d = 13'h0000;
        end
      end
      ST_HALT_DLY: begin
        cnt_d = cnt_q + 13'h0001;
        if (cnt_q == (long_q ? DLY_LONG_CYC : DLY_SHORT_CYC) - 13'h0001) begin
          // Waking source is served first; the normal decision then picks any other
          st_d = ST_RUN;
          take_d = 1'b1;
          vec_d = wake_q;
          {cc_d[CC_I1], cc_d[CC_I0]} = fld({spr1_q, spr0_q}, int'(wake_q));
        end
      end
      default: st_d = ST_RST_ACT;
    endcase

    // All three sources restart the sequence and drive the pin
    if (lvd_act || i_wdg_rst || (pin_low && !pdrv_q && pdrv_h_q == 2'h0)) begin
      st_d = ST_RST_ACT;
      cnt_d = 13'h0000;
      src_d = lvd_act ? SRC_LVD : (i_wdg_rst ? SRC_WDG : SRC_EXT);
      pdrv_d = 1'b1;
      take_d = 1'b0;
      osc_d = 1'b1;
    end
    run_d = (st_d == ST_RUN);
  end

  // New requests win over a clear in the same cycle
  always_comb begin
    set_v = {tli_fall, i_irq_evt} & {1'b1, en_q[4:0]};
    pend_d = (pend_q & ~clr_v) | set_v;
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      st_q <= ST_RST_ACT;
      cnt_q <= 13'h0000;
      src_q <= SRC_POR;
      long_q <= 1'b0;
      acc_q <= REG8_RST;
      x_q <= REG8_RST;
      y_q <= REG8_RST;
      cc_q <= CC_RST;
      pc_q <= PC_RST;
      spr0_q <= SPR_RST;
      spr1_q <= SPR_RST;
      en_q <= EN_RST;
      rd_q <= REG8_RST;
      pend_q <= 6'h00;
      arm_q <= 6'h00;
      wake_q <= 3'h0;
      vec_q <= 3'h0;
      take_q <= 1'b0;
      mrd_q <= 1'b0;
      maddr_q <= PC_RST;
      pdrv_q <= 1'b1;
      pdrv_h_q <= 2'h3;
      osc_q <= 1'b1;
      run_q <= 1'b0;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      src_q <= src_d;
      long_q <= long_d;
      acc_q <= acc_d;
      x_q <= x_d;
      y_q <= y_d;
      cc_q <= cc_d;
      pc_q <= pc_d;
      spr0_q <= spr0_d;
      spr1_q <= spr1_d;
      en_q <= en_d;
      rd_q <= rd_d;
      pend_q <= pend_d;
      arm_q <= arm_d;
      wake_q <= wake_d;
      vec_q <= vec_d;
      take_q <= take_d;
      mrd_q <= mrd_d;
      maddr_q <= maddr_d;
      pdrv_q <= pdrv_d;
      pdrv_h_q <= {pdrv_h_q[0], pdrv_q};
      osc_q <= osc_d;
      run_q <= run_d;
    end
  end

  assign o_rd_data = rd_q;
  assign o_acc = acc_q;
  assign o_x = x_q;
  assign o_y = y_q;
  assign o_pc = pc_q;
  assign o_cc = cc_q;
  assign o_irq_take = take_q;
  assign o_irq_vec = vec_q;
  assign o_mem_rd = mrd_q;
  assign o_mem_addr = maddr_q;
  assign o_rst_pin_o = 1'b0;
  assign o_rst_pin_oe_n = !pdrv_q;
  assign o_osc_en = osc_q;
  assign o_run = run_q;

  ////////////////////////////////////////////////////////////////////////////////
  // Checks
  a_pin_low_dly: assert property (@(posedge i_clk) disable iff (i_rst)
    st_q == ST_RST_DLY |-> !o_rst_pin_oe_n) else $error("reset pin released during delay");
  a_short_dly_len: assert property (@(posedge i_clk) disable iff (i_rst)
    (st_q == ST_RST_DLY && $past(st_q) != ST_RST_DLY && !long_q) |->
    ##256 (st_q == ST_VEC_HI || st_q == ST_RST_ACT)) else $error("short delay length wrong");
  a_vec_fetch: assert property (@(posedge i_clk) disable iff (i_rst)
    st_q == ST_VEC_HI |-> o_mem_rd && o_mem_addr == VEC_HI_ADDR ##1 o_mem_addr == VEC_LO_ADDR)
    else $error("vector fetch address wrong");
  a_y_untouched: assert property (@(posedge i_clk) disable iff (i_rst)
    o_irq_take |-> o_y == $past(o_y)) else $error("secondary pointer changed on entry");
  a_zero_flag: assert property (@(posedge i_clk) disable iff (i_rst)
    ($past(st_q == ST_RUN && i_cmd.vld && i_cmd.op == OP_ADD)) |-> o_cc[CC_Z] == (o_acc == 8'h00))
    else $error("zero flag wrong after add");
  a_carry_set: assert property (@(posedge i_clk) disable iff (i_rst)
    (st_q == ST_RUN && i_cmd.vld && i_cmd.op == OP_SCF && !lvd_act && !i_wdg_rst) |=> o_cc[CC_C])
    else $error("carry not set");
  a_halt_pri: assert property (@(posedge i_clk) disable iff (i_rst)
    st_q == ST_HALT |-> {o_cc[CC_I1], o_cc[CC_I0]} == PRI_L0) else $error("halt priority not 10");
  a_halt_wake: assert property (@(posedge i_clk) disable iff (i_rst)
    (o_irq_take && $past(st_q) == ST_HALT_DLY) |-> HALT_CAP[o_irq_vec])
    else $error("first service after halt not capable");
  a_entry_pri: assert property (@(posedge i_clk) disable iff (i_rst)
    o_irq_take |-> {o_cc[CC_I1], o_cc[CC_I0]} == fld({spr1_q, spr0_q}, int'(o_irq_vec)))
    else $error("entry priority not loaded");
  a_clear_drops: assert property (@(posedge i_clk) disable iff (i_rst)
    (clr_v != 6'h00) |=> ((pend_q & $past(clr_v & ~set_v)) == 6'h00)) else $error("clear left request");
endmodule // cps_core

// ---- design/cps_pkg.sv ----
// Constants, types and carriers for the CPU state, reset sequencer and interrupt entry core.
// Assumes a single 250 MHz CPU clock; no timescale in packages.
package cps_pkg;
  localparam int NSRC = 6;
  localparam int TLI_IDX = 5;
  // Wake-from-halt capable sources: IT0 and the top-level interrupt
  localparam logic [5:0] HALT_CAP = 6'h21;
  // Register port offsets
  localparam logic [2:0] A_SPR0 = 3'h0;
  localparam logic [2:0] A_SPR1 = 3'h1;
  localparam logic [2:0] A_EN = 3'h2;
  localparam logic [2:0] A_STAT = 3'h3;
  localparam logic [2:0] A_ACK = 3'h4;
  localparam logic [2:0] A_SYS = 3'h5;
  // Values after reset
  localparam logic [7:0] SPR_RST = 8'hFF;
  localparam logic [7:0] EN_RST = 8'h00;
  localparam logic [7:0] CC_RST = 8'hE8;
  localparam logic [7:0] REG8_RST = 8'h00;
  localparam logic [15:0] PC_RST = 16'h0000;
  // Condition code field positions
  localparam int CC_I1 = 5;
  localparam int CC_I0 = 3;
  localparam int CC_Z = 1;
  localparam int CC_C = 0;
  // Priority encodings {high bit, low bit}
  localparam logic [1:0] PRI_L0 = 2'h2;
  localparam logic [1:0] PRI_L1 = 2'h1;
  localparam logic [1:0] PRI_L2 = 2'h0;
  localparam logic [1:0] PRI_L3 = 2'h3;
  // Reset sequencer cycle counts
  localparam logic [12:0] ACT_EXT_CYC = 13'h0010;
  localparam logic [12:0] ACT_INT_CYC = 13'h0020;
  localparam logic [12:0] DLY_SHORT_CYC = 13'h0100;
  localparam logic [12:0] DLY_LONG_CYC = 13'h1000;
  localparam logic [15:0] VEC_HI_ADDR = 16'hFFFE;
  localparam logic [15:0] VEC_LO_ADDR = 16'hFFFF;
  // Reset source codes
  localparam logic [1:0] SRC_POR = 2'h0;
  localparam logic [1:0] SRC_EXT = 2'h1;
  localparam logic [1:0] SRC_LVD = 2'h2;
  localparam logic [1:0] SRC_WDG = 2'h3;

  typedef enum logic [4:0] {
    OP_NOP, OP_LD_A, OP_LD_X, OP_LD_Y, OP_ADD, OP_SUB, OP_AND, OP_OR, OP_SHL, OP_ROL, OP_BTJ,
    OP_SCF, OP_RCF, OP_BR_EQ, OP_BR_NE, OP_BR_C, OP_BR_NC, OP_RIM, OP_SIM, OP_RETURN_FROM_INTERRUPT_INSTRUCTION, OP_POP_CC,
    OP_HALT, OP_WFI, OP_LD_PCL, OP_LD_PCH
  } cps_op_t;

  typedef enum logic [3:0] {
    ST_RST_ACT, ST_RST_DLY, ST_VEC_HI, ST_VEC_LO, ST_VEC_END, ST_RUN, ST_WAIT, ST_HALT, ST_HALT_DLY
  } cps_state_t;

  typedef struct packed {
    logic vld;
    cps_op_t op;
    logic [7:0] data;
  } cps_cmd_t;

  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } cps_bus_t;
endpackage

// ---- testbench/cps_far_end.sv ----
// Far-side model: peripheral request lines, top-level pin, reset pin pull-down and reset sources.
// Assumes the bench owns the clock; every change lands by non-blocking assignment after a rising edge.
`timescale 1ns/100ps
module cps_far_end
  import cps_pkg::*;
(
  input wire logic i_clk,
  output logic [4:0] o_irq_evt,
  output logic o_tli_pin,
  output logic o_rst_pull_n,
  output logic o_lvd_rst,
  output logic o_wdg_rst
);
  initial begin
    o_irq_evt = 5'h00;
    o_tli_pin = 1'b1;
    o_rst_pull_n = 1'b1;
    o_lvd_rst = 1'b0;
    o_wdg_rst = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // One-cycle request pulses from the peripherals
  task automatic pulse_irq(input logic [4:0] m);
    @(posedge i_clk);
    o_irq_evt <= m;
    @(posedge i_clk);
    o_irq_evt <= 5'h00;
  endtask

  // Pin idles high; only the falling edge asks, so low is held long enough to be synchronised
  task automatic tli_fall();
    @(posedge i_clk);
    o_tli_pin <= 1'b0;
    repeat (4) @(posedge i_clk);
    o_tli_pin <= 1'b1;
  endtask

  // Held 4 cycles so the core's synchronisers cannot miss a source
  task automatic reset_src(input logic [1:0] s);
    @(posedge i_clk);
    o_rst_pull_n <= (s != SRC_EXT);
    o_lvd_rst <= (s == SRC_LVD);
    o_wdg_rst <= (s == SRC_WDG);
    repeat (4) @(posedge i_clk);
    o_rst_pull_n <= 1'b1;
    o_lvd_rst <= 1'b0;
    o_wdg_rst <= 1'b0;
  endtask
endmodule // cps_far_end

// ---- testbench/cps_core_tb_top.sv ----
// Self-checking bench: reset sequences, commands, register port, interrupt entry, clearing and wake.
// Assumes cps_pkg, cps_core and the far-side model cps_far_end.
`timescale 1ns/100ps
module cps_core_tb_top;
  import cps_pkg::*;
  logic i_clk;
  logic i_rst;
  cps_cmd_t cmd;
  cps_bus_t bus;
  logic opt_long;
  logic [7:0] mem_data;
  logic [4:0] evt;
  logic top_level_interrupt, pull_n, low_voltage_detector, wdg, rst_line;
  logic [7:0] rd_data, acc, x, y, cc, mem_unused;
  logic [15:0] pc, mem_addr;
  logic take, mem_rd, pin_o, pin_oe_n, osc_en, run;
  logic [2:0] vec;
  int n_fail;
  int total_checks;

  // Open-drain reset line with pull-up: low when either party pulls
  assign rst_line = (pin_oe_n ? 1'b1 : pin_o) & pull_n;

  cps_core dut (.i_clk(i_clk), .i_rst(i_rst), .i_cmd(cmd), .i_bus(bus), .i_irq_evt(evt), .i_tli_pin(top_level_interrupt),
    .i_rst_pin(rst_line), .i_lvd_rst(low_voltage_detector), .i_wdg_rst(wdg), .i_opt_long_dly(opt_long), .i_mem_data(mem_data),
    .o_rd_data(rd_data), .o_acc(acc), .o_x(x), .o_y(y), .o_pc(pc), .o_cc(cc), .o_irq_take(take),
    .o_irq_vec(vec), .o_mem_rd(mem_rd), .o_mem_addr(mem_addr), .o_rst_pin_o(pin_o),
    .o_rst_pin_oe_n(pin_oe_n), .o_osc_en(osc_en), .o_run(run));

  cps_far_end far (.i_clk(i_clk), .o_irq_evt(evt), .o_tli_pin(top_level_interrupt), .o_rst_pull_n(pull_n),
    .o_lvd_rst(low_voltage_detector), .o_wdg_rst(wdg));

  always #2 i_clk = ~i_clk;

  // Vector memory: high byte 12, low byte 34
  always @(posedge i_clk) begin
    mem_data <= (mem_addr == VEC_HI_ADDR) ? 8'h12 : 8'h34;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input logic [19:0] got, input logic [19:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge i_clk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge i_clk);
    bus.wr <= 1'b0;
  endtask

  task automatic bus_rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge i_clk);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge i_clk);
    bus.rd <= 1'b0;
    #1;
    d = rd_data;
  endtask

  task automatic rdchk(input logic [2:0] a, input logic [7:0] e);
    logic [7:0] d;
    bus_rd(a, d);
    chk(d, e);
  endtask

  // Status read then acknowledge read on the very next edge; returns the status byte
  task automatic clr(output logic [7:0] st);
    @(posedge i_clk);
    bus <= '{addr: A_STAT, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge i_clk);
    bus.addr <= A_ACK;
    #1;
    st = rd_data;
    @(posedge i_clk);
    bus.rd <= 1'b0;
  endtask

  task automatic op(input cps_op_t o, input logic [7:0] d);
    @(posedge i_clk);
    cmd <= '{vld: 1'b1, op: o, data: d};
    @(posedge i_clk);
    cmd.vld <= 1'b0;
    #1;
  endtask

  // s: 0 run, 1 entry, 2 vector read, 3 reset pin driven
  task automatic wait_hi(input int s, input int lim);
    int n;
    logic hit;
    hit = 1'b0;
    for (n = 0; n < lim && hit !== 1'b1; n++) begin
      @(posedge i_clk);
      #1;
      hit = (s == 0) ? run : (s == 1) ? take : (s == 2) ? mem_rd : !pin_oe_n;
    end
    if (hit !== 1'b1) begin
      n_fail++;
      $display("mismatch at %0t: got %h expected %h", $time, s, 1);
      results();
    end
  endtask

  task automatic quiet(input int lim);
    logic seen;
    seen = 1'b0;
    repeat (lim) begin
      @(posedge i_clk);
      #1;
      seen = seen | take;
    end
    chk(seen, 1'b0);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Count driven-low cycles up to the first vector read, then follow the fetch into run
  task automatic seq_chk(input int dly, input logic [1:0] src);
    int n, k;
    logic [7:0] d;
    wait_hi(3, 64);
    chk(osc_en, 1'b1);
    n = 0;
    for (k = 0; k < 5000 && mem_rd !== 1'b1; k++) begin
      @(posedge i_clk);
      #1;
      if (pin_oe_n === 1'b0) n++;
    end
    chk({mem_rd, mem_addr}, {1'b1, VEC_HI_ADDR});
    chk(n >= dly && n <= dly + 64, 1'b1);
    @(posedge i_clk);
    #1;
    chk(mem_addr, VEC_LO_ADDR);
    wait_hi(0, 8);
    chk(pc, 16'h1234);
    bus_rd(A_SYS, d);
    chk(d[7:5], {dly == 4096, src});
    $display("test reset source %0d delay %0d done", src, dly);
  endtask

  task automatic t_regs();
    rdchk(A_SPR0, SPR_RST);
    rdchk(A_SPR1, SPR_RST);
    rdchk(A_EN, EN_RST);
    rdchk(3'h7, 8'h00);
    wr(A_STAT, 8'hFF);
    rdchk(A_STAT, 8'h00);
    chk(cc, CC_RST);
    $display("test registers done");
  endtask

  task automatic t_alu();
    op(OP_LD_A, 8'hFF);
    op(OP_ADD, 8'h01);
    chk({acc, cc[1:0]}, {8'h00, 2'h3});
    op(OP_SUB, 8'h01);
    chk({acc, cc[1:0]}, {8'hFF, 2'h1});
    op(OP_RCF, 8'h00);
    chk(cc[0], 1'b0);
    op(OP_SCF, 8'h00);
    chk(cc[0], 1'b1);
    op(OP_RCF, 8'h00);
    op(OP_LD_A, 8'h80);
    op(OP_SHL, 8'h00);
    chk({acc, cc[1:0]}, {8'h00, 2'h3});
    op(OP_LD_X, 8'hA5);
    op(OP_LD_Y, 8'h5A);
    chk({x, y}, 16'hA55A);
    op(OP_LD_PCH, 8'hAB);
    chk(pc[15:8], 8'hAB);
    op(OP_RIM, 8'h00);
    chk({cc[5], cc[3]}, PRI_L0);
    op(OP_SIM, 8'h00);
    chk({cc[5], cc[3]}, PRI_L3);
    $display("test commands done");
  endtask

  // Both sources at the same software level: hardware order decides
  task automatic t_irq();
    logic [7:0] d;
    wr(A_EN, 8'h03);
    wr(A_SPR0, 8'hF0);
    far.pulse_irq(5'h03);
    op(OP_RIM, 8'h00);
    wait_hi(1, 20);
    chk({vec, cc[5], cc[3], y}, {3'h0, PRI_L2, 8'h5A});
    clr(d);
    chk(d, 8'h03);
    rdchk(A_STAT, 8'h00);
    wr(A_EN, 8'h01);
    far.pulse_irq(5'h02);
    rdchk(A_STAT, 8'h00);
    op(OP_SIM, 8'h00);
    far.pulse_irq(5'h01);
    clr(d);
    op(OP_RIM, 8'h00);
    quiet(30);
    $display("test entry and clearing done");
  endtask

  // A non-capable request must not wake halt; the top-level pin does, after the delay
  task automatic t_halt();
    logic [7:0] d;
    wr(A_EN, 8'h03);
    op(OP_HALT, 8'h00);
    @(posedge i_clk);
    #1;
    chk({cc[5], cc[3], osc_en}, {PRI_L0, 1'b0});
    far.pulse_irq(5'h02);
    quiet(40);
    chk(osc_en, 1'b0);
    far.tli_fall();
    wait_hi(1, 400);
    chk({vec, cc[5], cc[3], osc_en}, {3'(TLI_IDX), PRI_L3, 1'b1});
    clr(d);
    chk(d, 8'h22);
    op(OP_RIM, 8'h00);
    op(OP_WFI, 8'h00);
    chk(run, 1'b0);
    far.pulse_irq(5'h02);
    wait_hi(1, 20);
    chk(vec, 3'h1);
    clr(d);
    $display("test halt and wait done");
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    i_clk = 1'b0;
    i_rst = 1'b1;
    cmd = '0;
    bus = '0;
    opt_long = 1'b0;
    mem_data = 8'h00;
    n_fail = 0;
    total_checks = 0;
    repeat (8) @(posedge i_clk);
    i_rst <= 1'b0;
    seq_chk(256, SRC_POR);
    t_regs();
    t_alu();
    t_irq();
    t_halt();
    for (int s = 1; s < 4; s++) begin
      far.reset_src(2'(s));
      seq_chk(256, 2'(s));
    end
    @(posedge i_clk);
    opt_long <= 1'b1;
    far.reset_src(SRC_WDG);
    seq_chk(4096, SRC_WDG);
    results();
  end
endmodule // cps_core_tb_top
